/* File: rtl/rtcsc_sec_counter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtcsc_defs.svh"
module rtcsc_sec_counter
(
   input wire logic clk, // block clock
   input wire logic rst_b, // synchronised reset, active low
   input wire logic tick, // one-second pulse
   input wire logic halt, // stop counting
   input wire logic bcd, // decimal coding select
   input wire logic load, // load pulse from commit
   input wire rtcsc_pkg::rtcsc_sec_t load_val, // committed seconds value
   output rtcsc_pkg::rtcsc_sec_t count_q, // running seconds
   output logic wrap_q // carry to minutes
);
   rtcsc_pkg::rtcsc_sec_t next_val;
   logic next_wrap;

   always_comb
   begin
      next_val = count_q + 7'h01;
      next_wrap = 1'b0;
      if (bcd)
      begin
         if (count_q[3:0] == `RTCSC_BCD_UNIT_MAX)
         begin
            if (count_q[6:4] == `RTCSC_BCD_TENS_MAX)
            begin
               next_val = 7'h00;
               next_wrap = 1'b1;
            end
            else
            begin
               next_val = {count_q[6:4] + 3'h1, 4'h0};
            end
         end
      end
      else if (count_q == `RTCSC_SEC_MAX_BIN)
      begin
         next_val = 7'h00;
         next_wrap = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count_q <= 7'h00;
         wrap_q <= 1'b0;
      end
      else if (load)
      begin
         count_q <= load_val;
         wrap_q <= 1'b0;
      end
      else if (tick && !halt)
      begin
         count_q <= next_val;
         wrap_q <= next_wrap;
      end
      else
      begin
         wrap_q <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/rtcsc_update_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtcsc_defs.svh"
module rtcsc_update_ctrl
#(
   parameter int unsigned XFER_CYCLES = `RTCSC_XFER_TIME_NS / `RTCSC_CLK_PERIOD_NS,
   parameter int unsigned CNT_W = 22
)
(
   input wire logic clk, // 200 MHz block clock
   input wire logic rst_b, // rtc undervoltage reset, active low
   input wire logic [7:0] reg_addr, // register address
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire rtcsc_pkg::rtcsc_byte_t reg_wdata, // write data
   output rtcsc_pkg::rtcsc_byte_t reg_rdata_q, // read data
   output logic reg_rvalid_q, // read data valid
   input wire logic sec_tick, // one-second pulse, same clock
   input wire logic bcd_mode, // decimal coding select
   output rtcsc_pkg::rtcsc_sec_t sec_count_q, // running seconds
   output logic sec_wrap_q, // minute carry pulse
   output logic freeze_sec_q, // seconds halted
   output logic power_loss_detect_en_q, // detection enabled
   output logic [11:0] power_loss_window_ms_q // decoded window in ms
);
   localparam logic [CNT_W-1:0] XFER_LAST = CNT_W'(XFER_CYCLES - 1);
   // reset images, so reset fields are picked by bit position at full width
   localparam rtcsc_pkg::rtcsc_byte_t CTRL_RST = `RTCSC_RST_CTRL;
   localparam rtcsc_pkg::rtcsc_byte_t PLOSS_RST = `RTCSC_RST_PLOSS;
   localparam rtcsc_pkg::rtcsc_byte_t SEC_RST = `RTCSC_RST_SEC;

   logic rst_meta_q;
   logic rst_sync_q;
   logic clear_flags_on_read_q;
   logic [1:0] req_q;
   logic [1:0] done_q;
   logic [1:0] start;
   logic [1:0] finish;
   logic [1:0] done_clr;
   logic [1:0] power_loss_window_sel_q;
   rtcsc_pkg::rtcsc_sec_t sec_wbuf_q;
   rtcsc_pkg::rtcsc_sec_t sec_rbuf_q;
   rtcsc_pkg::rtcsc_byte_t rd_mux;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_ploss;
   logic wr_sec;
   logic rd_stat;

   // reset release through two flops
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   assign wr_ctrl = reg_wr && (reg_addr == `RTCSC_ADDR_CTRL);
   assign wr_stat = reg_wr && (reg_addr == `RTCSC_ADDR_STAT);
   assign wr_ploss = reg_wr && (reg_addr == `RTCSC_ADDR_PLOSS);
   assign wr_sec = reg_wr && (reg_addr == `RTCSC_ADDR_SEC);
   assign rd_stat = reg_rd && (reg_addr == `RTCSC_ADDR_STAT);

   assign start[0] = wr_ctrl && reg_wdata[`RTCSC_CTRL_COMMIT];
   assign start[1] = wr_ctrl && reg_wdata[`RTCSC_CTRL_SNAP];

   // done flags: clear on status read, or by writing 0 when read-clear is off
   assign done_clr[0] = (clear_flags_on_read_q && rd_stat)
      || (!clear_flags_on_read_q && wr_stat && !reg_wdata[`RTCSC_STAT_COMMIT_DONE]);
   assign done_clr[1] = (clear_flags_on_read_q && rd_stat)
      || (!clear_flags_on_read_q && wr_stat && !reg_wdata[`RTCSC_STAT_SNAP_DONE]);

   // one transfer engine per direction: 0 commit, 1 snapshot
   for (genvar ch = 0; ch < 2; ch++)
   begin : g_xfer
      rtcsc_pkg::rtcsc_xfer_e st_q;
      logic [CNT_W-1:0] cnt_q;

      assign finish[ch] = (st_q == rtcsc_pkg::XFER_WAIT) && (cnt_q == XFER_LAST);

      always_ff @(posedge clk or negedge rst_sync_q)
      begin
         if (!rst_sync_q)
         begin
            st_q <= rtcsc_pkg::XFER_IDLE;
            cnt_q <= '0;
            req_q[ch] <= 1'b0;
         end
         else
         begin
            case (st_q)
               rtcsc_pkg::XFER_IDLE:
               begin
                  cnt_q <= '0;
                  if (start[ch])
                  begin
                     st_q <= rtcsc_pkg::XFER_WAIT;
                     req_q[ch] <= 1'b1;
                  end
               end
               rtcsc_pkg::XFER_WAIT:
               begin
                  if (cnt_q == XFER_LAST)
                  begin
                     st_q <= rtcsc_pkg::XFER_IDLE;
                     cnt_q <= '0;
                     req_q[ch] <= 1'b0;
                  end
                  else
                  begin
                     cnt_q <= cnt_q + 1'b1;
                  end
               end
               default:
               begin
                  st_q <= rtcsc_pkg::XFER_IDLE;
                  cnt_q <= '0;
                  req_q[ch] <= 1'b0;
               end
            endcase
         end
      end

      // set wins over a clear in the same cycle
      always_ff @(posedge clk or negedge rst_sync_q)
      begin
         if (!rst_sync_q)
         begin
            done_q[ch] <= 1'b0;
         end
         else
         begin
            done_q[ch] <= finish[ch] || (done_q[ch] && !done_clr[ch]);
         end
      end
   end

   // control register fields
   always_ff @(posedge clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         clear_flags_on_read_q <= CTRL_RST[`RTCSC_CTRL_CLEAR_FLAGS_ON_READ];
         freeze_sec_q <= CTRL_RST[`RTCSC_CTRL_FREEZE];
      end
      else if (wr_ctrl)
      begin
         clear_flags_on_read_q <= reg_wdata[`RTCSC_CTRL_CLEAR_FLAGS_ON_READ];
         freeze_sec_q <= reg_wdata[`RTCSC_CTRL_FREEZE];
      end
   end

   // power-loss configuration and decoded window
   always_ff @(posedge clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         power_loss_window_sel_q <= PLOSS_RST[`RTCSC_PLOSS_WIN_HI:`RTCSC_PLOSS_WIN_LO];
         power_loss_detect_en_q <= PLOSS_RST[`RTCSC_PLOSS_EN];
         power_loss_window_ms_q <= `RTCSC_WIN_STEP_MS;
      end
      else
      begin
         if (wr_ploss)
         begin
            power_loss_window_sel_q <= reg_wdata[`RTCSC_PLOSS_WIN_HI:`RTCSC_PLOSS_WIN_LO];
            power_loss_detect_en_q <= reg_wdata[`RTCSC_PLOSS_EN];
         end
         power_loss_window_ms_q <= 12'({2'h0, power_loss_window_sel_q} + 4'h1) * `RTCSC_WIN_STEP_MS;
      end
   end

   // seconds write buffer and read buffer
   always_ff @(posedge clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         sec_wbuf_q <= SEC_RST[`RTCSC_SEC_MSB:0];
         sec_rbuf_q <= SEC_RST[`RTCSC_SEC_MSB:0];
      end
      else
      begin
         if (wr_sec)
         begin
            sec_wbuf_q <= reg_wdata[`RTCSC_SEC_MSB:0];
         end
         if (finish[1])
         begin
            sec_rbuf_q <= sec_count_q;
         end
      end
   end

   rtcsc_sec_counter u_sec
   (
      .clk(clk),
      .rst_b(rst_sync_q),
      .tick(sec_tick),
      .halt(freeze_sec_q),
      .bcd(bcd_mode),
      .load(finish[0]),
      .load_val(sec_wbuf_q),
      .count_q(sec_count_q),
      .wrap_q(sec_wrap_q)
   );

   // read data multiplexer; reserved bits read as reset default
   always_comb
   begin
      rd_mux = 8'h00;
      case (reg_addr)
         `RTCSC_ADDR_CTRL:
         begin
            rd_mux[`RTCSC_CTRL_COMMIT] = req_q[0];
            rd_mux[`RTCSC_CTRL_CLEAR_FLAGS_ON_READ] = clear_flags_on_read_q;
            rd_mux[`RTCSC_CTRL_FREEZE] = freeze_sec_q;
            rd_mux[`RTCSC_CTRL_RSVD1] = CTRL_RST[`RTCSC_CTRL_RSVD1];
            rd_mux[`RTCSC_CTRL_SNAP] = req_q[1];
         end
         `RTCSC_ADDR_STAT:
         begin
            rd_mux[`RTCSC_STAT_COMMIT_DONE] = done_q[0];
            rd_mux[`RTCSC_STAT_SNAP_DONE] = done_q[1];
         end
         `RTCSC_ADDR_PLOSS:
         begin
            rd_mux[`RTCSC_PLOSS_WIN_HI:`RTCSC_PLOSS_WIN_LO] = power_loss_window_sel_q;
            rd_mux[`RTCSC_PLOSS_EN] = power_loss_detect_en_q;
         end
         `RTCSC_ADDR_SEC:
         begin
            rd_mux[`RTCSC_SEC_MSB:0] = sec_rbuf_q;
         end
         default:
         begin
            rd_mux = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         reg_rdata_q <= 8'h00;
         reg_rvalid_q <= 1'b0;
      end
      else
      begin
         reg_rvalid_q <= reg_rd;
         if (reg_rd)
         begin
            reg_rdata_q <= rd_mux;
         end
      end
   end
endmodule
`default_nettype wire

/* File: shared/rtcsc_defs.svh */
// Behaviour
// - commit-request write 1 loads counters after delay
// - commit request clears itself after the load
// - snapshot-request write 1 copies counters to buffers
// - snapshot request clears itself after the copy
// - commit-done flag set on actual load
// - snapshot-done flag set on actual copy
// - clear-on-read set: status read clears flags
// - clear-on-read clear: write 0 clears flags
// - seconds-halt stops seconds counter and chain
// - window field decodes 0.5s to 2.0s
// - power-loss detection only while bit7 set
// - binary seconds 0 to 59, bit7 reserved
// - decimal mode: tens 0-5, units 0-9
// - seconds writes go only to write buffer
// - seconds reads change only on snapshot
// - decimal-coding select chooses binary or decimal
`ifndef RTCSC_DEFS_SVH
`define RTCSC_DEFS_SVH

`define RTCSC_ADDR_CTRL 8'h04
`define RTCSC_ADDR_STAT 8'h05
`define RTCSC_ADDR_PLOSS 8'h06
`define RTCSC_ADDR_SEC 8'h07

`define RTCSC_RST_CTRL 8'h0a
`define RTCSC_RST_STAT 8'h00
`define RTCSC_RST_PLOSS 8'h00
`define RTCSC_RST_SEC 8'h00

`define RTCSC_CTRL_COMMIT 0
`define RTCSC_CTRL_CLEAR_FLAGS_ON_READ 1
`define RTCSC_CTRL_FREEZE 2
`define RTCSC_CTRL_RSVD1 3
`define RTCSC_CTRL_SNAP 4
`define RTCSC_STAT_COMMIT_DONE 0
`define RTCSC_STAT_SNAP_DONE 1
`define RTCSC_PLOSS_WIN_LO 2
`define RTCSC_PLOSS_WIN_HI 3
`define RTCSC_PLOSS_EN 7
`define RTCSC_SEC_MSB 6

`define RTCSC_SEC_MAX_BIN 7'h3b
`define RTCSC_BCD_UNIT_MAX 4'h9
`define RTCSC_BCD_TENS_MAX 3'h5

`define RTCSC_XFER_TIME_NS 15000000
`define RTCSC_CLK_PERIOD_NS 5
`define RTCSC_WIN_STEP_MS 12'h1f4

`endif

/* File: shared/rtcsc_pkg.sv */
package rtcsc_pkg;
   typedef logic [7:0] rtcsc_byte_t;
   typedef logic [6:0] rtcsc_sec_t;
   typedef enum logic {XFER_IDLE, XFER_WAIT} rtcsc_xfer_e;
endpackage

/* File: verification/rtcsc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcsc_host_model
(
   input wire logic clk, // clock
   output logic [7:0] reg_addr, // addr
   output logic reg_wr, // write
   output logic reg_rd, // read
   output rtcsc_pkg::rtcsc_byte_t reg_wdata, // wdata
   input wire rtcsc_pkg::rtcsc_byte_t reg_rdata_q, // rdata
   input wire logic reg_rvalid_q // rvalid
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   // idle bus shows the inverse of the last value
   task wr(input logic [7:0] a, input rtcsc_pkg::rtcsc_byte_t d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task rd(input logic [7:0] a, output rtcsc_pkg::rtcsc_byte_t d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = (reg_rvalid_q === 1'b1) ? reg_rdata_q : 8'hxx;
   endtask
   // status reads until the done flag reads 1, giving up after 20 reads
   task poll(input int b, output rtcsc_pkg::rtcsc_byte_t s);
      s = 8'h00;
      repeat (20)
      begin
         if (s[b] !== 1'b1)
            rd(8'h05, s);
      end
   endtask
endmodule
`default_nettype wire

/* File: verification/rtcsc_update_ctrl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcsc_update_ctrl_checker
(
   input wire logic clk, // clock
   input wire logic rst_b, // reset
   input wire logic [7:0] reg_addr, // addr
   input wire logic reg_wr, // write
   input wire rtcsc_pkg::rtcsc_byte_t reg_wdata, // wdata
   input wire logic sec_tick, // tick
   input wire logic bcd_mode, // coding
   input wire rtcsc_pkg::rtcsc_sec_t sec_count_q, // seconds
   input wire logic sec_wrap_q, // carry
   input wire logic freeze_sec_q, // halt
   input wire logic power_loss_detect_en_q, // enable
   input wire logic [11:0] power_loss_window_ms_q // window
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire logic run = sec_tick && !freeze_sec_q;
   a_halt_no_wrap: assert property (freeze_sec_q |=> !sec_wrap_q)
      else $error("carry while halted");
   a_tick_step: assert property (run && !bcd_mode && sec_count_q < 7'h3b |=>
      sec_count_q == $past(sec_count_q) + 7'h1) else $error("no step");
   a_bin_wrap: assert property (run && !bcd_mode && sec_count_q == 7'h3b |=>
      sec_count_q == 7'h00 && sec_wrap_q) else $error("binary wrap");
   a_bcd_wrap: assert property (run && bcd_mode && sec_count_q == 7'h59 |=> sec_count_q == 7'h00)
      else $error("decimal wrap");
   a_bcd_carry: assert property (run && bcd_mode && sec_count_q[3:0] == 4'h9 && sec_count_q[6:4] < 3'h5
      |=> sec_count_q == {$past(sec_count_q[6:4]) + 3'h1, 4'h0}) else $error("decimal carry");
   a_halt_bit: assert property (reg_wr && reg_addr == 8'h04 |=> freeze_sec_q == $past(reg_wdata[2]))
      else $error("halt bit");
   a_detect_en: assert property (reg_wr && reg_addr == 8'h06 |=>
      power_loss_detect_en_q == $past(reg_wdata[7])) else $error("detect enable");
   a_window_ms: assert property (reg_wr && reg_addr == 8'h06 |-> ##2
      power_loss_window_ms_q == 12'h1f4 * (12'($past(reg_wdata[3:2], 2)) + 12'h1)) else $error("window");
endmodule
bind rtcsc_update_ctrl rtcsc_update_ctrl_checker i_rtcsc_update_ctrl_checker (.clk, .rst_b, .reg_addr,
   .reg_wr, .reg_wdata, .sec_tick, .bcd_mode, .sec_count_q, .sec_wrap_q, .freeze_sec_q,
   .power_loss_detect_en_q, .power_loss_window_ms_q);
`default_nettype wire

/* File: verification/rtcsc_update_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcsc_update_ctrl_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic sec_tick = 1'b0;
   logic bcd_mode = 1'b0;
   logic [7:0] reg_addr;
   logic reg_wr, reg_rd, reg_rvalid_q, freeze_sec_q, detect_en;
   rtcsc_pkg::rtcsc_byte_t reg_wdata, reg_rdata_q, s;
   rtcsc_pkg::rtcsc_sec_t sec_count_q;
   logic [11:0] win_ms;
   int err_total = 0;
   int check_count = 0;
   always #2.5 clk = ~clk;
   rtcsc_update_ctrl #(.XFER_CYCLES(8)) i_rtcsc_update_ctrl (.clk, .rst_b, .reg_addr, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .sec_tick, .bcd_mode, .sec_count_q, .sec_wrap_q(),
      .freeze_sec_q, .power_loss_detect_en_q(detect_en), .power_loss_window_ms_q(win_ms));
   rtcsc_host_model i_rtcsc_host_model (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q,
      .reg_rvalid_q);
   task finish_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input string n, input logic [11:0] e, input logic [11:0] g);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task rchk(input logic [7:0] a, input logic [7:0] e);
      i_rtcsc_host_model.rd(a, s);
      chk($sformatf("reg %h", a), e, s);
   endtask
   task tick;
      @(posedge clk) sec_tick <= 1'b1;
      @(posedge clk) sec_tick <= 1'b0;
      #1;
   endtask
   task cm(input logic [7:0] v);
      i_rtcsc_host_model.wr(8'h07, v);
      i_rtcsc_host_model.wr(8'h04, 8'h03);
      i_rtcsc_host_model.poll(0, s);
   endtask
   task do_reset;
      @(posedge clk) rst_b <= 1'b0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   task t_reset;
      rchk(8'h04, 8'h0a);
      rchk(8'h05, 8'h00);
      rchk(8'h06, 8'h00);
      rchk(8'h07, 8'h00);
      rchk(8'h08, 8'h00);
      chk("en", 12'h000, detect_en);
      chk("win", 12'h1f4, win_ms);
      $display("t_reset done");
   endtask
   task t_commit;
      i_rtcsc_host_model.wr(8'h07, 8'h2a);
      rchk(8'h07, 8'h00);
      i_rtcsc_host_model.wr(8'h04, 8'h03);
      rchk(8'h04, 8'h0b);
      chk("sec", 12'h000, sec_count_q);
      i_rtcsc_host_model.poll(0, s);
      chk("flag", 12'h001, s);
      chk("sec", 12'h02a, sec_count_q);
      rchk(8'h04, 8'h0a);
      rchk(8'h05, 8'h00);
      rchk(8'h07, 8'h00);
      $display("t_commit done");
   endtask
   task t_snap;
      i_rtcsc_host_model.wr(8'h04, 8'h12);
      rchk(8'h04, 8'h1a);
      i_rtcsc_host_model.poll(1, s);
      chk("flag", 12'h002, s);
      rchk(8'h07, 8'h2a);
      rchk(8'h04, 8'h0a);
      rchk(8'h05, 8'h00);
      $display("t_snap done");
   endtask
   task t_nofcur;
      i_rtcsc_host_model.wr(8'h04, 8'h01);
      i_rtcsc_host_model.poll(0, s);
      rchk(8'h05, 8'h01);
      i_rtcsc_host_model.wr(8'h05, 8'h01);
      rchk(8'h05, 8'h01);
      i_rtcsc_host_model.wr(8'h05, 8'h02);
      rchk(8'h05, 8'h00);
      i_rtcsc_host_model.wr(8'h04, 8'h02);
      $display("t_nofcur done");
   endtask
   task t_count;
      cm(8'h3b);
      tick;
      chk("sec", 12'h000, sec_count_q);
      tick;
      chk("sec", 12'h001, sec_count_q);
      i_rtcsc_host_model.wr(8'h04, 8'h06);
      tick;
      chk("sec", 12'h001, sec_count_q);
      i_rtcsc_host_model.wr(8'h04, 8'h02);
      @(posedge clk) bcd_mode <= 1'b1;
      cm(8'h59);
      repeat (11) tick;
      chk("sec", 12'h010, sec_count_q);
      @(posedge clk) bcd_mode <= 1'b0;
      $display("t_count done");
   endtask
   task t_ploss;
      for (int w = 0; w < 4; w++)
      begin
         i_rtcsc_host_model.wr(8'h06, {1'b1, 3'h0, 2'(w), 2'h0});
         repeat (2) @(posedge clk);
         #1;
         chk("win", 12'h1f4 * 12'(w + 1), win_ms);
         chk("en", 12'h001, detect_en);
      end
      rchk(8'h06, 8'h8c);
      i_rtcsc_host_model.wr(8'h06, 8'h04);
      rchk(8'h06, 8'h04);
      chk("en", 12'h000, detect_en);
      $display("t_ploss done");
   endtask
   initial
   begin
      do_reset;
      t_reset;
      t_commit;
      t_snap;
      t_nofcur;
      t_count;
      t_ploss;
      do_reset;
      t_reset;
      finish_test;
   end
   initial
   begin
      #100000;
      err_total++;
      finish_test;
   end
endmodule
`default_nettype wire
